// ### rtl/cpmc_pkg.sv
// Package: map, field values, modes and timing for clock/power control
package cpmc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [3:0] OFS_PLL_CFG = 4'h0;
  localparam logic [3:0] OFS_CLK_SEL = 4'h1;
  localparam logic [3:0] OFS_CLK_DIV = 4'h2;
  localparam logic [3:0] OFS_MODE = 4'h3;
  localparam logic [3:0] OFS_WAKE_EN = 4'h4;
  localparam logic [3:0] OFS_WAKE_STAT = 4'h5;
  localparam logic [3:0] OFS_PLL_EN = 4'h6;
  // Fast loop: code n gives FAST_MIN_MHZ + n * FAST_STEP_MHZ
  localparam int FAST_MIN_MHZ = 15;
  localparam int FAST_MAX_MHZ = 96;
  localparam int FAST_STEP_MHZ = 3;
  localparam logic [4:0] FAST_CODE_MAX =
    5'((FAST_MAX_MHZ - FAST_MIN_MHZ) / FAST_STEP_MHZ);
  localparam logic [4:0] PLL_CFG_RST = FAST_CODE_MAX;
  // Loop enables: bit 0 fast (96MHz), bit 1 27MHz, bit 2 12MHz
  localparam int PLL_N = 3;
  localparam logic [2:0] PLL_EN_RST = 3'h7;
  // System clock sources
  localparam logic [1:0] SRC_32K = 2'h0;
  localparam logic [1:0] SRC_12M = 2'h1;
  localparam logic [1:0] SRC_6M = 2'h2;
  localparam logic [1:0] CLK_SEL_RST = SRC_12M;
  // Divider exponent: ratio 1/2^n, n up to 7 (1/128)
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam int DIV_CNT_W = 7;
  // Mode entry keys written to OFS_MODE
  localparam logic [15:0] KEY_WAIT = 16'h5a01;
  localparam logic [15:0] KEY_HALT = 16'h5a02;
  localparam logic [15:0] KEY_STOP_RESUME = 16'h5a03;
  localparam logic [15:0] KEY_SLEEP = 16'h5a04;
  // Mode read-back codes
  localparam logic [2:0] MC_NORMAL = 3'h0;
  localparam logic [2:0] MC_WAIT = 3'h1;
  localparam logic [2:0] MC_HALT = 3'h2;
  localparam logic [2:0] MC_STOP_RESUME = 3'h3;
  localparam logic [2:0] MC_SLEEP = 3'h4;
  localparam logic [2:0] MC_RESET = 3'h5;
  // Wake source bits
  localparam int WAKE_W = 3;
  localparam int WAKE_IRQ = 0;
  localparam int WAKE_TMR = 1;
  localparam int WAKE_KEY = 2;
  localparam logic [2:0] WAKE_EN_RST = 3'h7;
  // Reset pulse after wake, least time
  localparam int CLK_MHZ = 250;
  localparam int RST_PULSE_NS = 100;
  localparam logic [4:0] RST_PULSE_CYC =
    5'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [2:0] {
    M_NORMAL, M_WAIT, M_HALT, M_STOP_RESUME, M_SLEEP, M_RST_CPU, M_RST_SYS
  } cpmc_mode_t;
endpackage

// ### rtl/cpmc_link_if.sv
// Interface: control between the sequencer, divider and wake detector
`timescale 1ns/1ps
interface cpmc_link_if;
  logic [1:0] src_sel;
  logic [2:0] div_log2;
  logic run;
  logic tick_32k;
  logic tick_12m;
  logic tick_6m;
  logic sys_tick;
  logic [2:0] wake_en;
  logic [2:0] wake_hit;
  modport ctl (output src_sel, div_log2, run, tick_32k, tick_12m, tick_6m,
    wake_en, input sys_tick, wake_hit);
  modport div (input src_sel, div_log2, run, tick_32k, tick_12m, tick_6m,
    output sys_tick);
  modport wake (input wake_en, output wake_hit);
endinterface

// ### rtl/cpmc_clkdiv.sv
// Source select and power-of-two divider for the system clock tick
`timescale 1ns/1ps
module cpmc_clkdiv (
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Sync reset
  input wire logic ce, // Clock enable
  cpmc_link_if.div lk // Control link
);
  import cpmc_pkg::*;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick_q;
  logic src_tick;
  logic [6:0] mask;

  function automatic logic [6:0] div_mask(input logic [2:0] n);
    div_mask = 7'((8'h01 << n) - 8'h01);
  endfunction

  assign src_tick = (lk.src_sel == SRC_32K) ? lk.tick_32k :
                    (lk.src_sel == SRC_6M) ? lk.tick_6m : lk.tick_12m;
  assign mask = div_mask(lk.div_log2);
  assign cnt_d = lk.run && src_tick ? 7'(cnt_q + 7'h01) : cnt_q;
  assign lk.sys_tick = tick_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick_q <= lk.run && src_tick && ((cnt_q & mask) == mask);
    end
  end

  property p_div_stop;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && !lk.run |=> !tick_q;
  endproperty
  a_div_stop: assert property (p_div_stop)
    else $error("system tick while system clock stopped");
endmodule

// ### rtl/cpmc_wake.sv
// Wake event detector, runs on the ungated core clock
`timescale 1ns/1ps
module cpmc_wake (
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic irq_evt, // Interrupt pending, same domain
  input wire logic tmr_evt, // Timer event, same domain
  input wire logic [1:0] key_pin, // Key-change pins, async
  cpmc_link_if.wake lk // Control link
);
  import cpmc_pkg::*;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] key_q;
  logic [2:0] hit_q;
  logic [1:0] fill_q;
  logic armed;
  logic key_stable;
  logic key_chg;
  logic [2:0] raw;

  assign key_stable = (s2_q == s3_q);
  // Chain must fill first, else a pin held high fakes a change
  assign armed = (fill_q == 2'h3);
  assign key_chg = armed && key_stable && (s3_q != key_q);
  assign raw = {key_chg, tmr_evt, irq_evt};
  assign lk.wake_hit = hit_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      key_q <= 2'h0;
      fill_q <= 2'h0;
      hit_q <= 3'h0;
    end else if (ce) begin
      s1_q <= key_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (!armed) begin
        fill_q <= 2'(fill_q + 2'h1);
        key_q <= s2_q;
      end else if (key_stable) begin
        key_q <= s3_q;
      end
      hit_q <= raw & lk.wake_en;
    end
  end

  property p_wake_evt;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && irq_evt && lk.wake_en[WAKE_IRQ] |=> hit_q[WAKE_IRQ];
  endproperty
  a_wake_evt: assert property (p_wake_evt)
    else $error("enabled interrupt did not raise wake");

  property p_key_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && key_chg && lk.wake_en[WAKE_KEY] |=> hit_q[WAKE_KEY];
  endproperty
  a_key_wake: assert property (p_key_wake)
    else $error("key change lost by wake detector");

  c_key_wake: cover property (@(posedge ref_clk) hit_q[WAKE_KEY]);
endmodule

// ### rtl/cpmc_top.sv
// Clock selection, divider and power mode sequencer
// Notes on behaviour
// - Three loops, 96MHz, 27MHz and 12MHz, each with an enable output.
// - Fast loop programmable 15 to 96MHz in 3MHz steps.
// - System clock source chosen among 32768Hz, 12MHz and 6MHz.
// - Divider cuts the selected system clock by up to 1/128.
// - Normal mode keeps CPU, system, RTC clocks and power enable on.
// - Wait stops CPU clock only; wake resumes at next instruction.
// - Halt stops CPU and system clocks, drops power; wake resets CPU.
// - Stop-resume mode like Halt but wake resumes without reset.
// - Sleep stops all clocks, drops power; wake resets whole system.
// - Interrupt, timer or key change wakes from low power.
`timescale 1ns/1ps
module cpmc_top (
  input wire logic ref_clk, // 250 MHz core clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic ce, // Clock enable, freezes state
  input wire logic [cpmc_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [cpmc_pkg::DATA_W-1:0] wr_data, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [cpmc_pkg::DATA_W-1:0] rd_data, // Read data, next cycle
  input wire logic tick_32k, // 32768Hz source tick
  input wire logic tick_12m, // 12MHz source tick
  input wire logic tick_6m, // 6MHz source tick
  input wire logic irq_evt, // Interrupt pending
  input wire logic tmr_evt, // Timer event
  input wire logic [1:0] key_pin, // Key-change pins
  output logic [cpmc_pkg::PLL_N-1:0] pll_en, // Loop enables
  output logic [4:0] pll_fast_code, // Fast loop step code
  output logic [1:0] sys_src_sel, // System clock source
  output logic sys_clk_tick, // Divided system clock enable
  output logic cpu_clk_en, // CPU clock gate
  output logic sys_clk_en, // System clock gate
  output logic rtc_clk_en, // RTC clock gate
  output logic external_power_enable_out, // External power enable
  output logic cpu_reset, // CPU reset request
  output logic sys_reset // System reset request
);
  import cpmc_pkg::*;

  cpmc_link_if lk ();
  cpmc_mode_t state_q;
  cpmc_mode_t state_d;
  logic [4:0] pll_code_q;
  logic [2:0] pll_en_q;
  logic [1:0] src_q;
  logic [2:0] div_q;
  logic [2:0] wake_en_q;
  logic [2:0] wake_stat_q;
  logic [4:0] rst_cnt_q;
  logic [15:0] rd_data_q;
  logic tick_q;
  logic cpu_q;
  logic sys_q;
  logic rtc_q;
  logic pwr_q;
  logic cpu_rst_q;
  logic sys_rst_q;

  // Decode
  logic sel_pll_cfg;
  logic sel_clk_sel;
  logic sel_clk_div;
  logic sel_mode;
  logic sel_wake_en;
  logic sel_wake_stat;
  logic sel_pll_en;
  logic wake_any;
  logic low_power;
  logic pll_ok;
  logic src_ok;
  logic [2:0] mode_code;
  logic [15:0] rd_mux;
  logic [2:0] wake_stat_d;

  assign sel_pll_cfg = (addr == OFS_PLL_CFG);
  assign sel_clk_sel = (addr == OFS_CLK_SEL);
  assign sel_clk_div = (addr == OFS_CLK_DIV);
  assign sel_mode = (addr == OFS_MODE);
  assign sel_wake_en = (addr == OFS_WAKE_EN);
  assign sel_wake_stat = (addr == OFS_WAKE_STAT);
  assign sel_pll_en = (addr == OFS_PLL_EN);

  assign pll_ok = (wr_data[4:0] <= FAST_CODE_MAX);
  assign src_ok = (wr_data[1:0] != 2'h3);

  assign wake_any = |lk.wake_hit;
  assign low_power = (state_q == M_WAIT) || (state_q == M_HALT) ||
                     (state_q == M_STOP_RESUME) || (state_q == M_SLEEP);

  assign mode_code = (state_q == M_WAIT) ? MC_WAIT :
                     (state_q == M_HALT) ? MC_HALT :
                     (state_q == M_STOP_RESUME) ? MC_STOP_RESUME :
                     (state_q == M_SLEEP) ? MC_SLEEP :
                     (state_q == M_NORMAL) ? MC_NORMAL : MC_RESET;

  // Unmapped addresses read zero
  always_comb begin
    if (sel_pll_cfg) begin
      rd_mux = {11'h000, pll_code_q};
    end else if (sel_clk_sel) begin
      rd_mux = {14'h0000, src_q};
    end else if (sel_clk_div) begin
      rd_mux = {13'h0000, div_q};
    end else if (sel_mode) begin
      rd_mux = {13'h0000, mode_code};
    end else if (sel_wake_en) begin
      rd_mux = {13'h0000, wake_en_q};
    end else if (sel_wake_stat) begin
      rd_mux = {13'h0000, wake_stat_q};
    end else if (sel_pll_en) begin
      rd_mux = {13'h0000, pll_en_q};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Write-one-clear; a new hit in the same cycle wins
  assign wake_stat_d =
    (wake_stat_q & ~((wr && sel_wake_stat) ? wr_data[2:0] : 3'h0)) |
    lk.wake_hit;

  assign lk.src_sel = src_q;
  assign lk.div_log2 = div_q;
  assign lk.tick_32k = tick_32k;
  assign lk.tick_12m = tick_12m;
  assign lk.tick_6m = tick_6m;
  assign lk.wake_en = wake_en_q;
  assign lk.run = sys_q;

  cpmc_clkdiv u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .lk(lk.div)
  );

  cpmc_wake u_wake (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .irq_evt(irq_evt),
    .tmr_evt(tmr_evt),
    .key_pin(key_pin),
    .lk(lk.wake)
  );

  // entry only by key write in Normal
  always_comb begin
    state_d = state_q;
    case (state_q)
      M_NORMAL: begin
        if (wr && sel_mode) begin
          if (wr_data == KEY_WAIT) begin
            state_d = M_WAIT;
          end else if (wr_data == KEY_HALT) begin
            state_d = M_HALT;
          end else if (wr_data == KEY_STOP_RESUME) begin
            state_d = M_STOP_RESUME;
          end else if (wr_data == KEY_SLEEP) begin
            state_d = M_SLEEP;
          end
        end
      end
      M_WAIT, M_STOP_RESUME: begin
        if (wake_any) begin
          state_d = M_NORMAL;
        end
      end
      M_HALT: begin
        if (wake_any) begin
          state_d = M_RST_CPU;
        end
      end
      M_SLEEP: begin
        if (wake_any) begin
          state_d = M_RST_SYS;
        end
      end
      M_RST_CPU, M_RST_SYS: begin
        if (rst_cnt_q == 5'h01) begin
          state_d = M_NORMAL;
        end
      end
      default: state_d = M_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= M_NORMAL;
      rst_cnt_q <= 5'h00;
    end else if (ce) begin
      state_q <= state_d;
      rst_cnt_q <= (state_d != state_q) ? RST_PULSE_CYC :
                   (rst_cnt_q != 5'h00) ? 5'(rst_cnt_q - 5'h01) : 5'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_q <= 1'b1;
      sys_q <= 1'b1;
      rtc_q <= 1'b1;
      pwr_q <= 1'b1;
      cpu_rst_q <= 1'b0;
      sys_rst_q <= 1'b0;
    end else if (ce) begin
      cpu_q <= (state_d == M_NORMAL) || (state_d == M_RST_CPU) ||
               (state_d == M_RST_SYS);
      sys_q <= (state_d != M_HALT) && (state_d != M_STOP_RESUME) &&
               (state_d != M_SLEEP);
      rtc_q <= (state_d != M_SLEEP);
      pwr_q <= (state_d != M_HALT) && (state_d != M_STOP_RESUME) &&
               (state_d != M_SLEEP);
      cpu_rst_q <= (state_d == M_RST_CPU);
      sys_rst_q <= (state_d == M_RST_SYS);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pll_code_q <= PLL_CFG_RST;
      pll_en_q <= PLL_EN_RST;
      src_q <= CLK_SEL_RST;
      div_q <= DIV_RST;
      wake_en_q <= WAKE_EN_RST;
      wake_stat_q <= 3'h0;
      rd_data_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (wr && sel_pll_cfg && pll_ok) begin
        pll_code_q <= wr_data[4:0];
      end
      if (wr && sel_pll_en) begin
        pll_en_q <= wr_data[2:0];
      end
      if (wr && sel_clk_sel && src_ok) begin
        src_q <= wr_data[1:0];
      end
      if (wr && sel_clk_div) begin
        div_q <= wr_data[2:0];
      end
      if (wr && sel_wake_en) begin
        wake_en_q <= wr_data[2:0];
      end
      wake_stat_q <= wake_stat_d;
      rd_data_q <= rd ? rd_mux : 16'h0000;
      tick_q <= lk.sys_tick;
    end
  end

  assign rd_data = rd_data_q;
  assign pll_en = pll_en_q;
  assign pll_fast_code = pll_code_q;
  assign sys_src_sel = src_q;
  assign sys_clk_tick = tick_q;
  assign cpu_clk_en = cpu_q;
  assign sys_clk_en = sys_q;
  assign rtc_clk_en = rtc_q;
  assign external_power_enable_out = pwr_q;
  assign cpu_reset = cpu_rst_q;
  assign sys_reset = sys_rst_q;

  property p_pll_range;
    @(posedge ref_clk) disable iff (!rst_n) pll_code_q <= FAST_CODE_MAX;
  endproperty
  a_pll_range: assert property (p_pll_range)
    else $error("fast loop code out of range");

  property p_src_write;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && wr && sel_clk_sel && src_ok |=> src_q == $past(wr_data[1:0]);
  endproperty
  a_src_write: assert property (p_src_write)
    else $error("clock source write not taken");

  property p_normal;
    @(posedge ref_clk) disable iff (!rst_n)
      state_q == M_NORMAL && $past(state_q) == M_NORMAL |->
        cpu_q && sys_q && rtc_q && pwr_q;
  endproperty
  a_normal: assert property (p_normal)
    else $error("a gate is off in normal mode");

  property p_wait_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && state_q == M_WAIT && wake_any |=>
        state_q == M_NORMAL && cpu_q && !cpu_rst_q;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait did not resume cleanly");

  property p_halt_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && state_q == M_HALT && wake_any |=> cpu_rst_q [*2];
  endproperty
  a_halt_wake: assert property (p_halt_wake)
    else $error("halt wake did not reset cpu");

  property p_stop_resume;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && state_q == M_STOP_RESUME && !wake_any |=>
        !cpu_q && !sys_q && rtc_q && !pwr_q;
  endproperty
  a_stop_resume: assert property (p_stop_resume)
    else $error("stop-resume gating wrong");

  property p_sleep_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && state_q == M_SLEEP && wake_any |=> sys_rst_q && !cpu_rst_q;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep wake did not reset system");

  property p_sleep_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      ce && state_q == M_NORMAL && wr && sel_mode && wr_data == KEY_SLEEP
        |=> !rtc_q && !pwr_q && !sys_q && !cpu_q;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("sleep entry left a clock on");

  c_wait: cover property (@(posedge ref_clk) state_q == M_WAIT);
  c_halt_rst: cover property (@(posedge ref_clk) cpu_rst_q);
  c_sleep_rst: cover property (@(posedge ref_clk) sys_rst_q);
  c_tick: cover property (@(posedge ref_clk) tick_q && div_q == 3'h7);
endmodule

// ### dv/cpmc_tb.sv
// Self-checking bench for the clock and power mode controller
`timescale 1ns/1ps
module testbench;
  import cpmc_pkg::*;
  localparam logic [15:0] KEYS [4] = '{KEY_WAIT, KEY_HALT, KEY_STOP_RESUME,
    KEY_SLEEP};
  localparam logic [2:0] MCS [4] = '{MC_WAIT, MC_HALT, MC_STOP_RESUME,
    MC_SLEEP};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rd_data;
  logic [2:0] tk = 3'h0;
  logic irq_evt = 1'b0;
  logic tmr_evt = 1'b0;
  logic [1:0] key_pin = 2'h0;
  logic [2:0] pll_en;
  logic [4:0] pll_fast_code;
  logic [1:0] sys_src_sel;
  logic sys_clk_tick, cpu_clk_en, sys_clk_en, rtc_clk_en, pwr_en;
  logic cpu_reset, sys_reset;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_tick = 0;
  int n_crst = 0;
  int n_srst = 0;
  int c0, s0, t0, code, prev;

  cpmc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data),
    .tick_32k(tk[0]), .tick_12m(tk[1]), .tick_6m(tk[2]),
    .irq_evt(irq_evt), .tmr_evt(tmr_evt), .key_pin(key_pin),
    .pll_en(pll_en), .pll_fast_code(pll_fast_code),
    .sys_src_sel(sys_src_sel), .sys_clk_tick(sys_clk_tick),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .rtc_clk_en(rtc_clk_en), .external_power_enable_out(pwr_en),
    .cpu_reset(cpu_reset), .sys_reset(sys_reset));

  always #2 ref_clk = ~ref_clk;

  // Pulse widths measured as high cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (sys_clk_tick === 1'b1) n_tick <= n_tick + 1;
    if (cpu_reset === 1'b1) n_crst <= n_crst + 1;
    if (sys_reset === 1'b1) n_srst <= n_srst + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
    input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(what, rd_data, exp);
  endtask

  // Selected source pulses, the others jitter between them
  task automatic pulses(input int s, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      tk <= 3'(1 << s);
      @(posedge ref_clk);
      tk <= 3'($urandom) & ~3'(1 << s);
    end
    @(posedge ref_clk);
    tk <= 3'h0;
  endtask

  task automatic fire(input int src);
    @(posedge ref_clk);
    if (src == 0) irq_evt <= 1'b1;
    if (src == 1) tmr_evt <= 1'b1;
    if (src == 2) key_pin <= key_pin ^ 2'(1 << $urandom_range(0, 1));
    @(posedge ref_clk);
    irq_evt <= 1'b0;
    tmr_evt <= 1'b0;
  endtask

  function automatic logic [15:0] gates_now();
    return {12'h000, cpu_clk_en, sys_clk_en, rtc_clk_en, pwr_en};
  endfunction

  // Gate pattern cpu, sys, rtc, power per low-power mode
  function automatic logic [15:0] gate_exp(input int m);
    case (m)
      0: return 16'h0007;
      1, 2: return 16'h0002;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] rst_exp(input int m, input int want);
    return (m == want) ? 16'(RST_PULSE_CYC) : 16'h0000;
  endfunction

  function automatic logic [15:0] reg_rst(input int a);
    case (a)
      0: return 16'(PLL_CFG_RST);
      1: return 16'(CLK_SEL_RST);
      3: return 16'(MC_NORMAL);
      4: return 16'(WAKE_EN_RST);
      6: return 16'(PLL_EN_RST);
      default: return 16'h0000;
    endcase
  endfunction

  initial begin
    void'($urandom(32'ha3796759));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(1);
    chk("gates rst", gates_now(), 16'h000f);
    chk("pll_en rst", 16'(pll_en), 16'h0007);
    for (int a = 0; a < 16; a++) begin
      rd_chk("reg rst", 4'(a), reg_rst(a));
    end
    wr_reg(OFS_PLL_EN, 16'($urandom_range(0, 7)));
    settle(1);
    chk("pll_en", 16'(pll_en), 16'(wr_data[2:0]));
    // Step codes with both ends, then an out-of-range code
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 0 : (i == 1) ? 27 : $urandom_range(0, 27);
      wr_reg(OFS_PLL_CFG, 16'(code));
      settle(1);
      chk("fast code", 16'(pll_fast_code), 16'(code));
    end
    wr_reg(OFS_PLL_CFG, 16'($urandom_range(28, 31)));
    settle(1);
    chk("fast code hold", 16'(pll_fast_code), 16'(code));
    prev = 1;
    for (int s = 0; s < 4; s++) begin
      wr_reg(OFS_CLK_SEL, 16'(s));
      settle(1);
      if (s < 3) prev = s;
      chk("src sel", 16'(sys_src_sel), 16'(prev));
    end
    // Frozen clock enable drops a write
    @(posedge ref_clk);
    ce <= 1'b0;
    wr_reg(OFS_CLK_SEL, 16'(SRC_32K));
    @(posedge ref_clk);
    ce <= 1'b1;
    settle(1);
    chk("ce hold", 16'(sys_src_sel), 16'(prev));
    // Warm-up window first, then exactly four periods
    for (int n = 0; n < 8; n++) begin
      wr_reg(OFS_CLK_SEL, 16'(n % 3));
      wr_reg(OFS_CLK_DIV, 16'(n));
      rd_chk("div rd", OFS_CLK_DIV, 16'(n));
      pulses(n % 3, 1 << n);
      settle(4);
      t0 = n_tick;
      pulses(n % 3, 4 << n);
      settle(4);
      chk("div ticks", 16'(n_tick - t0), 16'h0004);
    end
    wr_reg(OFS_MODE, 16'h5a05 + 16'($urandom_range(0, 16'h00f0)));
    wr_reg(4'h9, KEY_SLEEP);
    settle(2);
    chk("no entry", gates_now(), 16'h000f);
    rd_chk("unmapped", 4'h9, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      for (int src = 0; src < 3; src++) begin
        wr_reg(OFS_MODE, KEYS[m]);
        settle(2);
        chk("gates low", gates_now(), gate_exp(m));
        rd_chk("mode", OFS_MODE, 16'(MCS[m]));
        if (m == 0) begin
          wr_reg(OFS_MODE, KEY_SLEEP);
          settle(1);
          chk("no rekey", gates_now(), gate_exp(0));
        end
        c0 = n_crst;
        s0 = n_srst;
        fire(src);
        settle(6);
        rd_chk("mode wake", OFS_MODE,
          16'((m % 2 == 1) ? MC_RESET : MC_NORMAL));
        settle(40);
        chk("gates back", gates_now(), 16'h000f);
        chk("cpu rst", 16'(n_crst - c0), rst_exp(m, 1));
        chk("sys rst", 16'(n_srst - s0), rst_exp(m, 3));
      end
    end
    // Masked source must not wake, an enabled one must
    wr_reg(OFS_WAKE_EN, 16'h0006);
    wr_reg(OFS_MODE, KEY_SLEEP);
    fire(0);
    settle(30);
    chk("masked", gates_now(), 16'h0000);
    s0 = n_srst;
    fire(2);
    settle(50);
    chk("key wake", gates_now(), 16'h000f);
    chk("key sys rst", 16'(n_srst - s0), 16'(RST_PULSE_CYC));
    wr_reg(OFS_WAKE_EN, 16'h0007);
    wr_reg(OFS_WAKE_STAT, 16'h0007);
    rd_chk("stat clr", OFS_WAKE_STAT, 16'h0000);
    c0 = n_crst;
    fire(1);
    settle(5);
    chk("normal evt", gates_now(), 16'h000f);
    chk("normal rst", 16'(n_crst - c0), 16'h0000);
    rd_chk("stat tmr", OFS_WAKE_STAT, 16'h0002);
    // Reset in mid low-power restores running defaults
    wr_reg(OFS_MODE, KEY_HALT);
    settle(2);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle(1);
    chk("gates rst2", gates_now(), 16'h000f);
    chk("code rst2", 16'(pll_fast_code), 16'(PLL_CFG_RST));
    chk("src rst2", 16'(sys_src_sel), 16'(CLK_SEL_RST));
    tally_and_finish();
  end
endmodule
